// File: pkg/rtc_ctl_regs.svh
// offsets, field positions, reset values and timing counts of the clock unit and its controller
`ifndef RTC_CTL_REGS_SVH
`define RTC_CTL_REGS_SVH
// ----------------------------------------------------------------
// configuration port map (byte addresses)
// ----------------------------------------------------------------
`define PORT_CTL_ADDR      8'h00
`define PORT_CNT_ADDR0     8'h01
`define PORT_MATCH_ADDR0   8'h06
`define PORT_BYTES_40      3'h5
// ----------------------------------------------------------------
// control/status byte fields and reset value
// ----------------------------------------------------------------
`define CTL_UNIT_RST_BIT   7
`define CTL_CNT_EN_BIT     6
`define CTL_VR_MATCH_BIT   5
`define CTL_MODE_HI        4
`define CTL_MODE_LO        3
`define CTL_CLR_MATCH_BIT  2
`define CTL_CNT_CLR_N_BIT  1
`define CTL_XTAL_OWN_BIT   0
`define CTL_RESET          8'h00
// ----------------------------------------------------------------
// timing counts
// ----------------------------------------------------------------
`define PRESCALE_EDGES     7'h40
// ----------------------------------------------------------------
// controller registers on the APB side
// ----------------------------------------------------------------
`define APB_REQ_OFS        8'h00
`define APB_CMD_OFS        8'h04
`define APB_STATUS_OFS     8'h08
`define APB_IRQ_OFS        8'h0C
`define APB_MASK_OFS       8'h10
`define APB_PORT_OFS       8'h14
`define IRQ_DONE_BIT       0
`define IRQ_MATCH_BIT      1
`endif

// File: pkg/rtc_ctl_pkg.sv
// types shared by the clock unit and its controller
package rtc_ctl_pkg;
    typedef enum logic [1:0] {OP_WRITE, OP_READ, OP_SLEEP, OP_STANDBY} op_e;

    typedef enum logic [2:0] {S_IDLE, S_PRE_DIS, S_WR_END, S_RD_WAIT, S_RD_TAKE} ctl_state_e;

    typedef struct packed {
        logic [7:0]  ctl;
        logic [1:0]  rst_pipe;
        logic [1:0]  tick_sync;
        logic        tick_prev;
        logic [39:0] count;
        logic [39:0] match;
        logic        hit;
        logic [7:0]  rdata;
        logic        match_out;
        logic        psm_out;
        logic [1:0]  mode;
        logic        sel;
    } dev_s;

    typedef struct packed {
        logic [6:0]  edges;
        logic        armed;
        logic        inc;
    } presc_s;

    typedef struct packed {
        ctl_state_e  state;
        logic [15:0] req;
        logic [7:0]  shadow;
        logic [7:0]  last_rd;
        logic [1:0]  irq_st;
        logic [1:0]  mask;
        logic        port_rst;
        logic        match_prev;
        logic        wen;
        logic [7:0]  addr;
        logic [7:0]  wdata;
        logic        reset_n;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic        irq;
    } ctlr_s;
endpackage

// File: pkg/config_port_if.sv
// byte-wide configuration port and match/oscillator outputs between controller and clock unit
`timescale 1ns/1ps
interface config_port_if;
    logic       config_port_reset_n;
    logic       config_write_strobe;
    logic [7:0] config_port_addr;
    logic [7:0] config_port_wdata;
    logic [7:0] config_port_rdata;
    logic       match_out;
    logic       power_seq_match_out;
    logic [1:0] osc_mode_out;
    logic       osc_select_out;

    modport device (
        input  config_port_reset_n, config_write_strobe, config_port_addr, config_port_wdata,
        output config_port_rdata, match_out, power_seq_match_out, osc_mode_out, osc_select_out
    );
    modport controller (
        output config_port_reset_n, config_write_strobe, config_port_addr, config_port_wdata,
        input  config_port_rdata, match_out, power_seq_match_out, osc_mode_out, osc_select_out
    );
endinterface

// File: src/tick_prescaler.sv
// crystal prescaler: waits out the start delay, then passes one increment per crystal edge
`timescale 1ns/1ps
module tick_prescaler (
    input  wire logic i_ref_clk,
    input  wire logic i_reset,
    input  wire logic i_run,
    input  wire logic i_edge,
    output logic      o_inc
);
    `include "rtc_ctl_regs.svh"

    rtc_ctl_pkg::presc_s st;
    rtc_ctl_pkg::presc_s next_st;

    // ----------------------------------------------------------------
    // start delay and increment pulse
    // ----------------------------------------------------------------
    // stopping clears the delay, so every restart waits the full edge count again
    always_comb begin
        next_st     = st;
        next_st.inc = 1'b0;
        if (!i_run) begin
            next_st.edges = 7'h00;
            next_st.armed = 1'b0;
        end else if (i_edge) begin
            if (st.armed) begin
                next_st.inc = 1'b1;
            end else if (st.edges == `PRESCALE_EDGES - 7'h01) begin
                next_st.armed = 1'b1;
                next_st.inc   = 1'b1;
            end else begin
                next_st.edges = st.edges + 7'h01;
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign o_inc = st.inc;
endmodule

// File: src/rtc_device.sv
// clock unit end: control/status byte, 40-bit counter, match value and match/oscillator outputs
// Operation
// - control bit 7 resets unit; release two cycles later
// - first increment after 64 crystal edges
// - disabling counting stops prescaler, keeps counter value
// - counter loads only while counting disabled
// - regulator bit set: both match outputs follow equality
// - regulator bit clear: both match outputs zero
// - two-bit mode field drives oscillator mode output
// - clear-on-match clears counter at equality
// - all-zero match value suppresses clear-on-match
// - counter clear bit low zeroes counter
// - crystal own bit drives oscillator select output
// - controller clears oscillator bit for sleep, sets it for standby
// - port writes on strobe, 8-bit address and data
// - port reset is active low
`timescale 1ns/1ps
module rtc_device (
    input  wire logic   i_ref_clk,
    input  wire logic   i_reset,
    input  wire logic   i_crystal_tick,
    config_port_if.device port,
    output logic [39:0] o_counter_value
);
    `include "rtc_ctl_regs.svh"

    rtc_ctl_pkg::dev_s st;
    rtc_ctl_pkg::dev_s next_st;

    logic       unit_rst;
    logic       run;
    logic       tick_edge;
    logic       inc;
    logic [7:0] addr;
    logic [2:0] cnt_idx;
    logic [2:0] match_idx;
    logic       is_cnt;
    logic       is_match;
    logic       at_match;
    logic       clr_allowed;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // byte lane of a 40-bit value, lane 0 is least significant
    function automatic logic [7:0] get_byte(input logic [39:0] v, input logic [2:0] idx);
        logic [7:0] b;
        b = 8'h00;
        case (idx)
            3'h0: b = v[7:0];
            3'h1: b = v[15:8];
            3'h2: b = v[23:16];
            3'h3: b = v[31:24];
            3'h4: b = v[39:32];
            default: b = 8'h00;
        endcase
        return b;
    endfunction

    function automatic logic [39:0] put_byte(input logic [39:0] v, input logic [2:0] idx,
                                             input logic [7:0] b);
        logic [39:0] r;
        r = v;
        case (idx)
            3'h0: r[7:0]   = b;
            3'h1: r[15:8]  = b;
            3'h2: r[23:16] = b;
            3'h3: r[31:24] = b;
            3'h4: r[39:32] = b;
            default: r = v;
        endcase
        return r;
    endfunction

    // ----------------------------------------------------------------
    // decode and unit reset
    // ----------------------------------------------------------------
    // the reset stays on while the bit is set and for two cycles after it clears
    assign unit_rst    = st.ctl[`CTL_UNIT_RST_BIT] | st.rst_pipe[0] | st.rst_pipe[1];
    assign run         = st.ctl[`CTL_CNT_EN_BIT] & ~unit_rst;
    // the first synchroniser stage is never looked at here
    assign tick_edge   = st.tick_sync[1] & ~st.tick_prev;
    assign addr        = port.config_port_addr;
    assign cnt_idx     = 3'(addr - `PORT_CNT_ADDR0);
    assign match_idx   = 3'(addr - `PORT_MATCH_ADDR0);
    assign is_cnt      = (addr >= `PORT_CNT_ADDR0) && (addr < `PORT_MATCH_ADDR0);
    assign is_match    = (addr >= `PORT_MATCH_ADDR0) && (addr < `PORT_MATCH_ADDR0 + 8'h05);
    assign at_match    = (st.count == st.match);
    assign clr_allowed = st.ctl[`CTL_CLR_MATCH_BIT] && (st.match != 40'h00_0000_0000);

    tick_prescaler u_prescaler (
        .i_ref_clk (i_ref_clk),
        .i_reset   (i_reset),
        .i_run     (run),
        .i_edge    (tick_edge),
        .o_inc     (inc)
    );

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        next_st           = st;
        next_st.tick_sync = {st.tick_sync[0], i_crystal_tick};
        next_st.tick_prev = st.tick_sync[1];
        next_st.rst_pipe  = {st.rst_pipe[0], st.ctl[`CTL_UNIT_RST_BIT]};

        // port writes: only while the strobe is high
        if (port.config_write_strobe) begin
            if (addr == `PORT_CTL_ADDR) begin
                next_st.ctl = port.config_port_wdata;
            end else if (is_cnt && !st.ctl[`CTL_CNT_EN_BIT]) begin
                // loads while counting are dropped silently
                next_st.count = put_byte(st.count, cnt_idx, port.config_port_wdata);
            end else if (is_match) begin
                next_st.match = put_byte(st.match, match_idx, port.config_port_wdata);
            end
        end

        // counter: reset, clear bit, then increment or clear on match
        if (unit_rst || !st.ctl[`CTL_CNT_CLR_N_BIT]) begin
            next_st.count = 40'h00_0000_0000;
        end else if (inc && run) begin
            // a pulse still in flight when counting stops must not overwrite a load
            if (clr_allowed && at_match) begin
                next_st.count = 40'h00_0000_0000;
            end else begin
                next_st.count = st.count + 40'h00_0000_0001;
            end
        end

        // equality sampled once per crystal tick
        if (unit_rst) begin
            next_st.hit = 1'b0;
        end else if (tick_edge) begin
            next_st.hit = at_match;
        end

        // match outputs are forced low whenever the regulator bit is clear
        next_st.match_out = st.ctl[`CTL_VR_MATCH_BIT] & next_st.hit;
        next_st.psm_out   = st.ctl[`CTL_VR_MATCH_BIT] & next_st.hit;
        next_st.mode      = st.ctl[`CTL_MODE_HI:`CTL_MODE_LO];
        next_st.sel       = st.ctl[`CTL_XTAL_OWN_BIT];

        // read data registered: valid one cycle after the address
        if (addr == `PORT_CTL_ADDR) begin
            next_st.rdata = st.ctl;
        end else if (is_cnt) begin
            next_st.rdata = get_byte(st.count, cnt_idx);
        end else if (is_match) begin
            next_st.rdata = get_byte(st.match, match_idx);
        end else begin
            next_st.rdata = 8'h00;
        end

        // port reset wins over the control byte, match value and read data; a counter load still lands
        if (!port.config_port_reset_n) begin
            next_st.ctl   = `CTL_RESET;
            next_st.match = 40'h00_0000_0000;
            next_st.rdata = 8'h00;
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------------------------------
    // outputs, all straight from flops
    // ----------------------------------------------------------------
    assign port.config_port_rdata   = st.rdata;
    assign port.match_out           = st.match_out;
    assign port.power_seq_match_out = st.psm_out;
    assign port.osc_mode_out        = st.mode;     // oscillator honours it only with select high
    assign port.osc_select_out      = st.sel;
    assign o_counter_value          = st.count;
endmodule

// File: src/rtc_controller.sv
// controller end: APB registers that drive the configuration port of the clock unit
`timescale 1ns/1ps
module rtc_controller (
    input  wire logic        i_ref_clk,
    input  wire logic        i_reset,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [7:0]  i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic [31:0]      o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    output logic             o_irq,
    config_port_if.controller port
);
    `include "rtc_ctl_regs.svh"

    rtc_ctl_pkg::ctlr_s st;
    rtc_ctl_pkg::ctlr_s next_st;

    logic       access;
    logic       busy;
    logic       cnt_target;
    logic [1:0] events;

    assign access     = i_psel & i_penable & ~st.pready;
    assign busy       = (st.state != rtc_ctl_pkg::S_IDLE);
    assign cnt_target = (st.req[15:8] >= `PORT_CNT_ADDR0) && (st.req[15:8] < `PORT_MATCH_ADDR0);

    // ----------------------------------------------------------------
    // next state: APB slave, command sequencer, interrupts
    // ----------------------------------------------------------------
    always_comb begin
        next_st            = st;
        next_st.pready     = access;
        next_st.pslverr    = 1'b0;
        next_st.match_prev = port.match_out;
        next_st.reset_n    = ~st.port_rst;
        events             = 2'b00;
        events[`IRQ_MATCH_BIT] = port.match_out & ~st.match_prev;

        // sequencer
        case (st.state)
            rtc_ctl_pkg::S_IDLE: begin
                next_st.wen = 1'b0;
            end
            rtc_ctl_pkg::S_PRE_DIS: begin
                // counting now off: issue the held load
                next_st.wen   = 1'b1;
                next_st.addr  = st.req[15:8];
                next_st.wdata = st.req[7:0];
                next_st.state = rtc_ctl_pkg::S_WR_END;
            end
            rtc_ctl_pkg::S_WR_END: begin
                next_st.wen   = 1'b0;
                next_st.state = rtc_ctl_pkg::S_IDLE;
                events[`IRQ_DONE_BIT] = 1'b1;
            end
            rtc_ctl_pkg::S_RD_WAIT: begin
                next_st.state = rtc_ctl_pkg::S_RD_TAKE;
            end
            rtc_ctl_pkg::S_RD_TAKE: begin
                next_st.last_rd = port.config_port_rdata;
                next_st.state   = rtc_ctl_pkg::S_IDLE;
                events[`IRQ_DONE_BIT] = 1'b1;
            end
            default: begin
                next_st.state = rtc_ctl_pkg::S_IDLE;
            end
        endcase

        // APB access phase, answered one cycle later
        next_st.prdata = 32'h0000_0000;
        if (access) begin
            case (i_paddr)
                `APB_REQ_OFS: begin
                    if (i_pwrite) next_st.req = i_pwdata[15:0];
                    next_st.prdata = {16'h0000, st.req};
                end
                `APB_CMD_OFS: begin
                    // commands while busy are refused with an error
                    if (i_pwrite && busy) begin
                        next_st.pslverr = 1'b1;
                    end else if (i_pwrite) begin
                        next_st.wen   = 1'b1;
                        next_st.addr  = st.req[15:8];
                        next_st.wdata = st.req[7:0];
                        next_st.state = rtc_ctl_pkg::S_WR_END;
                        case (rtc_ctl_pkg::op_e'(i_pwdata[1:0]))
                            rtc_ctl_pkg::OP_WRITE: begin
                                if (cnt_target && st.shadow[`CTL_CNT_EN_BIT]) begin
                                    // stop counting first so the load is not lost
                                    next_st.addr  = `PORT_CTL_ADDR;
                                    next_st.wdata = st.shadow & ~(8'h01 << `CTL_CNT_EN_BIT);
                                    next_st.state = rtc_ctl_pkg::S_PRE_DIS;
                                end
                            end
                            rtc_ctl_pkg::OP_READ: begin
                                next_st.wen   = 1'b0;
                                next_st.state = rtc_ctl_pkg::S_RD_WAIT;
                            end
                            rtc_ctl_pkg::OP_SLEEP: begin
                                next_st.addr  = `PORT_CTL_ADDR;
                                next_st.wdata = st.shadow & ~(8'h01 << `CTL_XTAL_OWN_BIT);
                            end
                            rtc_ctl_pkg::OP_STANDBY: begin
                                next_st.addr  = `PORT_CTL_ADDR;
                                next_st.wdata = st.shadow | (8'h01 << `CTL_XTAL_OWN_BIT);
                            end
                            default: next_st.state = rtc_ctl_pkg::S_WR_END;
                        endcase
                    end
                end
                `APB_STATUS_OFS: next_st.prdata = {8'h00, st.shadow, st.last_rd, 7'h00, busy};
                `APB_IRQ_OFS: begin
                    next_st.prdata = {30'h0000_0000, st.irq_st};
                    if (!i_pwrite) next_st.irq_st = 2'b00;
                end
                `APB_MASK_OFS: begin
                    if (i_pwrite) next_st.mask = i_pwdata[1:0];
                    next_st.prdata = {30'h0000_0000, st.mask};
                end
                `APB_PORT_OFS: begin
                    if (i_pwrite) next_st.port_rst = i_pwdata[0];
                    next_st.prdata = {31'h0000_0000, st.port_rst};
                end
                default: next_st.pslverr = 1'b1;
            endcase
        end

        // shadow follows every control byte written, a port reset restores it
        if (next_st.wen && next_st.addr == `PORT_CTL_ADDR) next_st.shadow = next_st.wdata;
        if (st.port_rst) next_st.shadow = `CTL_RESET;

        // new events win over the clearing read
        next_st.irq_st = next_st.irq_st | events;
        next_st.irq    = |(next_st.irq_st & next_st.mask);
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------------------------------
    // outputs from flops
    // ----------------------------------------------------------------
    assign o_prdata                 = st.prdata;
    assign o_pready                 = st.pready;
    assign o_pslverr                = st.pslverr;
    assign o_irq                    = st.irq;
    assign port.config_port_reset_n = st.reset_n;
    assign port.config_write_strobe = st.wen;
    assign port.config_port_addr    = st.addr;
    assign port.config_port_wdata   = st.wdata;
endmodule

// File: testbench/rtc_link_props.sv
// concurrent checks on the configuration port between controller and clock unit
`timescale 1ns/1ps
`include "rtc_ctl_regs.svh"
module rtc_link_props (
    input  wire logic       i_ref_clk,
    input  wire logic       i_reset,
    input  wire logic       config_port_reset_n,
    input  wire logic       config_write_strobe,
    input  wire logic [7:0] config_port_addr,
    input  wire logic [7:0] config_port_wdata,
    input  wire logic [7:0] config_port_rdata,
    input  wire logic       match_out,
    input  wire logic       power_seq_match_out,
    input  wire logic [1:0] osc_mode_out,
    input  wire logic       osc_select_out
);
    logic [7:0] ctl_copy;

    // mirror of the control byte; either reset clears it like the device does
    always_ff @(posedge i_ref_clk) begin
        if (i_reset || !config_port_reset_n)
            ctl_copy <= `CTL_RESET;
        else if (config_write_strobe && config_port_addr == `PORT_CTL_ADDR)
            ctl_copy <= config_port_wdata;
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_reset);

    sequence ctl_write;
        config_write_strobe && config_port_reset_n && config_port_addr == `PORT_CTL_ADDR;
    endsequence
    sequence ctl_read;
        !config_write_strobe && config_port_reset_n && config_port_addr == `PORT_CTL_ADDR;
    endsequence

    a_mode_tracks_field: assert property (ctl_write |->
        ##2 osc_mode_out == $past(config_port_wdata[`CTL_MODE_HI:`CTL_MODE_LO], 2))
        else $error("oscillator mode does not follow control field");
    a_select_tracks_bit: assert property (osc_select_out == $past(ctl_copy[0]))
        else $error("oscillator select does not follow control bit");
    a_match_off_gated: assert property (!ctl_copy[`CTL_VR_MATCH_BIT] &&
        !$past(ctl_copy[`CTL_VR_MATCH_BIT]) |-> !match_out && !power_seq_match_out)
        else $error("match output high with regulator bit clear");
    a_match_outs_pair: assert property (match_out == power_seq_match_out)
        else $error("match outputs differ");
    a_ctl_readback: assert property (ctl_read |=> config_port_rdata == $past(ctl_copy))
        else $error("control byte read back wrong");
    a_port_rst_rdata: assert property (!config_port_reset_n |=> config_port_rdata == 8'h00)
        else $error("read data not cleared in port reset");
    a_port_rst_release: assert property ($fell(i_reset) |-> ##[1:2] config_port_reset_n)
        else $error("port reset not released after system reset");
    a_strobe_burst: assert property (config_write_strobe [*2] |=> !config_write_strobe)
        else $error("write strobe longer than two cycles");
endmodule

// File: testbench/rtc_control_status_logic_tb_top.sv
// self-checking bench: APB controller driving the clock unit over the configuration port
`timescale 1ns/1ps
`include "rtc_ctl_regs.svh"
module rtc_control_status_logic_tb_top;
    logic        i_ref_clk      = 1'h0;
    logic        i_reset        = 1'h1;
    logic        i_crystal_tick = 1'h0;
    logic        i_psel         = 1'h0;
    logic        i_penable      = 1'h0;
    logic        i_pwrite       = 1'h0;
    logic [7:0]  i_paddr        = 8'h00;
    logic [31:0] i_pwdata       = 32'h0;
    logic [31:0] o_prdata;
    logic        o_pready;
    logic        o_pslverr;
    logic        o_irq;
    logic [39:0] o_counter_value;
    logic        tick_run       = 1'h0;
    logic [2:0]  div            = 3'h0;
    logic        last_err;
    logic [31:0] rd;
    int          error_cnt      = 0;
    int          comparisons    = 0;

    config_port_if link ();
    rtc_device rtc_device_i (.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_crystal_tick(i_crystal_tick),
        .port(link.device), .o_counter_value(o_counter_value));
    rtc_controller rtc_controller_i (.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_psel(i_psel),
        .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
        .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .o_irq(o_irq),
        .port(link.controller));
    rtc_link_props rtc_link_props_i (.i_ref_clk(i_ref_clk), .i_reset(i_reset),
        .config_port_reset_n(link.config_port_reset_n), .config_write_strobe(link.config_write_strobe),
        .config_port_addr(link.config_port_addr), .config_port_wdata(link.config_port_wdata),
        .config_port_rdata(link.config_port_rdata), .match_out(link.match_out),
        .power_seq_match_out(link.power_seq_match_out), .osc_mode_out(link.osc_mode_out),
        .osc_select_out(link.osc_select_out));

    // 10 MHz reference clock
    initial forever #50 i_ref_clk = ~i_ref_clk;

    // crystal tick, 16 reference cycles a period; stands still while stopped
    always @(posedge i_ref_clk) begin
        div <= div + 3'h1;
        if (tick_run && div == 3'h7)
            i_crystal_tick <= ~i_crystal_tick;
    end

    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one APB transfer; an idle cycle after it keeps strobes from being set twice at one edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        i_psel <= 1'h1;
        i_pwrite <= wr;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_ref_clk);
        i_penable <= 1'h1;
        do @(posedge i_ref_clk); while (o_pready !== 1'h1);
        rd = o_prdata;
        last_err = o_pslverr;
        i_psel <= 1'h0;
        i_penable <= 1'h0;
        @(posedge i_ref_clk);
    endtask

    // port command: op 0 write, 1 read, 2 sleep, 3 standby; waits for busy to drop
    task automatic cmd(input logic [1:0] op, input logic [7:0] a, input logic [7:0] d);
        apb(1'h1, `APB_REQ_OFS, {16'h0, a, d});
        apb(1'h1, `APB_CMD_OFS, {30'h0, op});
        do apb(1'h0, `APB_STATUS_OFS, 32'h0); while (rd[0] !== 1'h0);
    endtask

    task automatic ticks(input int n);
        repeat (n) @(posedge i_crystal_tick);
        repeat (10) @(posedge i_ref_clk);
    endtask

    task automatic end_sim();
        $display("errors %0d of %0d comparisons", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial begin
        repeat (12) @(posedge i_ref_clk);
        i_reset <= 1'h0;
        repeat (2) @(posedge i_ref_clk);
        cmd(2'h1, `PORT_CTL_ADDR, 8'h00);
        chk(rd[15:8], `CTL_RESET);
        apb(1'h1, 8'h40, 32'h0);
        chk(last_err, 1'h1);
        for (int m = 0; m < 4; m++) begin
            cmd(2'h0, `PORT_CTL_ADDR, {3'h0, m[1:0], 2'h1, m[0]});
            chk(link.osc_mode_out, m[1:0]);
            chk(link.osc_select_out, m[0]);
        end
        cmd(2'h1, `PORT_CTL_ADDR, 8'h00);
        chk(rd[15:8], 8'h1B);
        for (int op = 2; op < 4; op++) begin
            cmd(op[1:0], 8'h00, 8'h00);
            chk(link.osc_select_out, op[0]);
        end
        apb(1'h1, `APB_PORT_OFS, 32'h1);
        apb(1'h1, `APB_PORT_OFS, 32'h0);
        cmd(2'h1, `PORT_CTL_ADDR, 8'h00);
        chk(rd[15:8], 8'h00);
        // match at 5 with clear-on-match, regulator bit and counting on
        apb(1'h1, `APB_MASK_OFS, 32'h2);
        cmd(2'h0, `PORT_MATCH_ADDR0, 8'h05);
        cmd(2'h0, `PORT_CTL_ADDR, 8'h66);
        tick_run <= 1'h1;
        ticks(63);
        chk(o_counter_value, 40'h0);
        ticks(1);
        chk(o_counter_value, 40'h1);
        ticks(4);
        chk(o_counter_value, 40'h5);
        ticks(1);
        chk(o_counter_value, 40'h0);
        chk(link.match_out, 1'h1);
        chk(o_irq, 1'h1);
        apb(1'h0, `APB_IRQ_OFS, 32'h0);
        repeat (2) @(posedge i_ref_clk);
        chk(rd[1], 1'h1);
        chk(o_irq, 1'h0);
        // load while counting: the counter is stopped first and then holds
        cmd(2'h0, `PORT_CNT_ADDR0, 8'h07);
        ticks(3);
        chk(o_counter_value, 40'h7);
        // unit reset zeroes the counter; once released a load lands again
        cmd(2'h0, `PORT_CTL_ADDR, 8'hA6);
        chk(o_counter_value, 40'h0);
        cmd(2'h0, `PORT_CTL_ADDR, 8'h26);
        cmd(2'h0, `PORT_CNT_ADDR0, 8'h07);
        chk(o_counter_value, 40'h7);
        tick_run <= 1'h0;
        cmd(2'h0, `PORT_CTL_ADDR, 8'h00);
        chk(o_counter_value, 40'h0);
        // all-zero match: clear-on-match set but the first increment must still land
        cmd(2'h0, `PORT_MATCH_ADDR0, 8'h00);
        cmd(2'h0, `PORT_CTL_ADDR, 8'h46);
        tick_run <= 1'h1;
        ticks(64);
        chk(o_counter_value, 40'h1);
        tick_run <= 1'h0;
        end_sim();
    end

    // watchdog, well beyond the few thousand cycles the tests need
    initial begin
        repeat (20000) @(posedge i_ref_clk);
        error_cnt++;
        end_sim();
    end
endmodule
